// ===== ckswr_regs.sv
// Accessory switch control, irq enable and status registers with pin routing.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module ckswr_regs (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // Register port
    input  wire ckswr_pkg::ckswr_bus_t  bus,
    output logic [7:0]                  rdata,
    // Sensing inputs from pads, enables, mode select and conversion strobes
    input  wire ckswr_pkg::ckswr_sense_t sense_pin,
    input  wire logic                   data_sink_current_en,
    input  wire logic                   id_pullup_en,
    input  wire logic                   accessory_mode_sel,
    input  wire logic                   vendor_res_irq_en,
    input  wire logic                   res_convert_start,
    input  wire logic                   vendor_code_read,
    // Data pins, analog switch controls and interrupt
    input  wire logic                   data0_in,
    input  wire logic                   dp_in,
    output logic                        data1_out,
    output logic                        data2_oe,
    output logic                        dm_out,
    output logic                        dm_oe,
    output logic                        id_pin_ground_drive,
    output logic                        left_audio_pin_en,
    output logic                        right_audio_pin_en,
    output logic                        left_audio_pin,
    output logic                        right_audio_pin,
    output logic                        se_rx_disable,
    output logic                        alt_int
);
    import ckswr_pkg::*;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } ckswr_conv_t;

    logic [7:0]   sw;
    logic [7:0]   irqen;
    ckswr_sense_t s1;
    ckswr_sense_t s2;
    logic [2:0]   res_code_prev, res_code_q;
    logic [1:0]   line_state_prev, line_state_q;
    logic         d0_s1, d0_s2, dp_s1, dp_s2;
    logic         open_q, det_q, done_q;
    logic         resistor_measure_done;
    ckswr_conv_t  conv_state;
    logic [13:0]  conv_cnt;
    logic [7:0]   status;
    logic         data_detect_status;
    logic         id_open_status;

    // Three-address update: plain write, set ones, clear ones, masked.
    function automatic logic [7:0] tri_update(input logic [7:0] cur, input logic [7:0] wd,
                                              input logic [1:0] sel, input logic [7:0] mask);
        logic [7:0] nv;
        nv = cur;
        case (sel)
            2'd0: nv = wd;
            2'd1: nv = cur | wd;
            2'd2: nv = cur & ~wd;
            default: nv = cur;
        endcase
        return nv & mask;
    endfunction : tri_update

    // ==========================================================
    // Input synchronisers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1    <= '0;
            s2    <= '0;
            d0_s1 <= 1'b0;
            d0_s2 <= 1'b0;
            dp_s1 <= 1'b0;
            dp_s2 <= 1'b0;
        end else begin
            s1    <= sense_pin;
            s2    <= s1;
            d0_s1 <= data0_in;
            d0_s2 <= d0_s1;
            dp_s1 <= dp_in;
            dp_s2 <= dp_s1;
        end
    end

    // ==========================================================
    // Multi-bit pad words
    // Each bit of a pad word is synchronised on its own, so a word caught mid-change may show
    // a code that never existed; a word is taken only after two equal samples in a row.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_code_prev   <= '0;
            res_code_q      <= '0;
            line_state_prev <= '0;
            line_state_q    <= '0;
        end else begin
            res_code_prev   <= s2.res_code;
            line_state_prev <= s2.line_state;
            if (s2.res_code == res_code_prev) begin
                res_code_q <= res_code_prev;
            end
            if (s2.line_state == line_state_prev) begin
                line_state_q <= line_state_prev;
            end
        end
    end

    // ==========================================================
    // Control registers
    // switch register updates
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sw <= REG_RESET;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_SWITCH_WRITE) begin
                sw <= tri_update(sw, bus.wdata, 2'd0, SWITCH_MASK);
            end else if (bus.addr == ADDR_SWITCH_SET) begin
                sw <= tri_update(sw, bus.wdata, 2'd1, SWITCH_MASK);
            end else if (bus.addr == ADDR_SWITCH_CLEAR) begin
                sw <= tri_update(sw, bus.wdata, 2'd2, SWITCH_MASK);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irqen <= REG_RESET;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_IRQEN_WRITE) begin
                irqen <= tri_update(irqen, bus.wdata, 2'd0, IRQEN_MASK);
            end else if (bus.addr == ADDR_IRQEN_SET) begin
                irqen <= tri_update(irqen, bus.wdata, 2'd1, IRQEN_MASK);
            end else if (bus.addr == ADDR_IRQEN_CLEAR) begin
                irqen <= tri_update(irqen, bus.wdata, 2'd2, IRQEN_MASK);
            end
        end
    end

    // ==========================================================
    // Resistor conversion timer
    // done after conversion time, vendor read clears
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            conv_state            <= CONV_IDLE;
            conv_cnt              <= '0;
            resistor_measure_done <= 1'b0;
        end else begin
            // Done holds until the vendor code read; a finish in the same cycle still sets it.
            if (vendor_code_read) begin
                resistor_measure_done <= 1'b0;
            end
            case (conv_state)
                CONV_IDLE: begin
                    if (res_convert_start) begin
                        conv_state <= CONV_BUSY;
                        conv_cnt   <= 14'(CONV_CYCLES - 1);
                    end
                end
                CONV_BUSY: begin
                    if (conv_cnt == 14'h0000) begin
                        conv_state            <= CONV_IDLE;
                        resistor_measure_done <= 1'b1;
                    end else begin
                        conv_cnt <= conv_cnt - 14'h0001;
                    end
                end
                default: conv_state <= CONV_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Status and interrupt
    // floating indication needs pull-up
    assign id_open_status     = s2.id_open & id_pullup_en;
    // comparator valid with sink enabled and SE0
    assign data_detect_status = s2.dp_voltage & data_sink_current_en & (line_state_q == LINE_SE0);

    always_comb begin
        status    = '0;
        status[0] = id_open_status;
        status[1] = data_detect_status;
        status[5:3] = res_code_q;
        status[6] = resistor_measure_done;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            open_q <= 1'b0;
            det_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            open_q <= id_open_status;
            det_q  <= data_detect_status;
            done_q <= resistor_measure_done;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            alt_int <= 1'b0;
        end else begin
            alt_int <= (irqen[BIT_OPEN_RISE] & id_open_status & ~open_q)
                     | (irqen[BIT_OPEN_FALL] & ~id_open_status & open_q)
                     | (irqen[BIT_DET_IRQ] & (data_detect_status ^ det_q))
                     | ((irqen[BIT_RES_IRQ] | vendor_res_irq_en) & resistor_measure_done & ~done_q);
        end
    end

    // Read data is valid only in the cycle after the strobe.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata <= '0;
        end else if (bus.rd) begin
            if (bus.addr == ADDR_SWITCH_WRITE || bus.addr == ADDR_SWITCH_SET || bus.addr == ADDR_SWITCH_CLEAR) begin
                rdata <= sw;
            end else if (bus.addr == ADDR_IRQEN_WRITE || bus.addr == ADDR_IRQEN_SET
                         || bus.addr == ADDR_IRQEN_CLEAR) begin
                rdata <= irqen;
            end else if (bus.addr == ADDR_IRQ_STATUS) begin
                rdata <= status;
            end else begin
                rdata <= '0;
            end
        end else begin
            rdata <= '0;
        end
    end

    // ==========================================================
    // Pin routing
    // receive route or idle high
    assign data1_out = sw[BIT_RX_ROUTE] ? dp_s2 : 1'b1;
    assign dm_out = d0_s2;
    assign dm_oe  = sw[BIT_TX_ROUTE];
    assign id_pin_ground_drive = sw[BIT_ID_GND];
    assign left_audio_pin_en  = sw[BIT_LEFT_SW];
    assign right_audio_pin_en = sw[BIT_RIGHT_SW] | sw[BIT_MIC_SW];
    // serial data on enabled audio pins
    assign left_audio_pin  = left_audio_pin_en & sw[BIT_TX_ROUTE] & d0_s2;
    assign right_audio_pin = right_audio_pin_en & sw[BIT_RX_ROUTE] & dp_s2;
    assign se_rx_disable = sw[BIT_LEFT_SW] | sw[BIT_RIGHT_SW] | sw[BIT_MIC_SW];
    // data line 2 driven low unless tri-state selected in accessory mode
    assign data2_oe = ~(sw[BIT_DATA2_TRI] & accessory_mode_sel);

    // ==========================================================
    // Assertions
    set_wins_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.wr && bus.addr == ADDR_SWITCH_SET |=> (sw & $past(bus.wdata) & SWITCH_MASK) == ($past(bus.wdata) & SWITCH_MASK))
        else $error("switch set lost bits");
    clear_bits_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.wr && bus.addr == ADDR_IRQEN_CLEAR |=> (irqen & $past(bus.wdata)) == 8'h00)
        else $error("irq enable clear failed");
    data1_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !sw[BIT_RX_ROUTE] |-> data1_out)
        else $error("data line 1 not high");
    right_sw_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        right_audio_pin_en == (sw[BIT_RIGHT_SW] || sw[BIT_MIC_SW]))
        else $error("right audio switch wrong");
    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sw[0] == 1'b0 && irqen[7:6] == 2'b00 && irqen[4:3] == 2'b00)
        else $error("reserved bit set");
    read_status_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.rd && bus.addr == ADDR_IRQ_STATUS |=> rdata == $past(status))
        else $error("status read mismatch");
    open_rise_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irqen[BIT_OPEN_RISE] && $rose(id_open_status) |=> alt_int)
        else $error("missing float rise irq");
    det_change_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irqen[BIT_DET_IRQ] && $changed(data_detect_status) |=> alt_int)
        else $error("missing detect irq");
    conv_done_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        conv_state == CONV_BUSY && conv_cnt == 14'h0000 |=> resistor_measure_done)
        else $error("conversion done not set");
    se_rx_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sw[BIT_MIC_SW] |-> se_rx_disable)
        else $error("receivers not disabled");
    id_ground_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.wr && bus.addr == ADDR_SWITCH_WRITE && bus.wdata[BIT_ID_GND] |=> id_pin_ground_drive)
        else $error("id ground drive missing");
    tx_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.wr && bus.addr == ADDR_SWITCH_CLEAR && bus.wdata[BIT_TX_ROUTE] |=> !dm_oe)
        else $error("transmit route not cleared");
    left_sw_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.wr && bus.addr == ADDR_SWITCH_WRITE && bus.wdata[BIT_LEFT_SW] |=> left_audio_pin_en)
        else $error("left audio switch missing");
    data2_tri_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sw[BIT_DATA2_TRI] && accessory_mode_sel |-> !data2_oe)
        else $error("data line 2 still driven");
    left_uart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sw[BIT_LEFT_SW] && sw[BIT_TX_ROUTE] |-> left_audio_pin == dm_out)
        else $error("serial data missing on left audio");
    open_fall_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irqen[BIT_OPEN_FALL] && $fell(id_open_status) |=> alt_int)
        else $error("missing float fall irq");
    dp_unused_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.rd && bus.addr == ADDR_IRQ_STATUS |=> !rdata[2] && !rdata[7])
        else $error("unused status bit set");
    done_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (irqen[BIT_RES_IRQ] || vendor_res_irq_en) && $rose(resistor_measure_done) |=> alt_int)
        else $error("missing conversion irq");
    det_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !data_sink_current_en |-> !status[1])
        else $error("detect without sink current");
    done_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        vendor_code_read && conv_state == CONV_IDLE |=> !resistor_measure_done)
        else $error("conversion done not cleared");

endmodule : ckswr_regs

// ===== ckswr_pkg.sv
// Package of register map, field positions and timing constants for the accessory switch and irq block.
package ckswr_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [5:0] ADDR_SWITCH_WRITE = 6'h19;
    localparam logic [5:0] ADDR_SWITCH_SET   = 6'h1A;
    localparam logic [5:0] ADDR_SWITCH_CLEAR = 6'h1B;
    localparam logic [5:0] ADDR_IRQEN_WRITE  = 6'h1D;
    localparam logic [5:0] ADDR_IRQEN_SET    = 6'h1E;
    localparam logic [5:0] ADDR_IRQEN_CLEAR  = 6'h1F;
    localparam logic [5:0] ADDR_IRQ_STATUS   = 6'h20;

    // ==========================================================
    // Writable masks and reset values
    localparam logic [7:0] SWITCH_MASK  = 8'hFE;
    localparam logic [7:0] IRQEN_MASK   = 8'h27;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // ==========================================================
    // Field positions
    localparam int BIT_ID_GND    = 1;
    localparam int BIT_TX_ROUTE  = 2;
    localparam int BIT_RX_ROUTE  = 3;
    localparam int BIT_LEFT_SW   = 4;
    localparam int BIT_RIGHT_SW  = 5;
    localparam int BIT_MIC_SW    = 6;
    localparam int BIT_DATA2_TRI = 7;
    localparam int BIT_OPEN_RISE = 0;
    localparam int BIT_OPEN_FALL = 1;
    localparam int BIT_DET_IRQ   = 2;
    localparam int BIT_RES_IRQ   = 5;

    // ==========================================================
    // Resistor codes and conversion timing
    localparam logic [2:0] RES_CODE_FLOAT = 3'h5;
    localparam logic [2:0] RES_CODE_ERROR = 3'h7;
    localparam int CLK_MHZ          = 50;
    localparam int CONV_TIME_US     = 282;
    localparam int CONV_CYCLES      = CONV_TIME_US * CLK_MHZ;
    localparam logic [1:0] LINE_SE0 = 2'h0;

    // Register bus request.
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ckswr_bus_t;

    // Analog sensing results from the pad ring.
    typedef struct packed {
        logic       id_open;
        logic       dp_voltage;
        logic [2:0] res_code;
        logic [1:0] line_state;
    } ckswr_sense_t;

endpackage : ckswr_pkg

// ===== ckswr_link_model.sv
// Link-side model driving the serial transmit line and the accessory mode select.
`timescale 1ns/1ps
module ckswr_link_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Requests from the bench
    input  wire logic routes_ready,
    input  wire logic tx_bit,
    // Link-driven levels
    output logic      accessory_mode_sel,
    output logic      data0_in
);
    // ==========================================================
    // Mode select
    // Mode after routes.
    always_ff @(posedge ref_clk) begin
        accessory_mode_sel <= sys_rst ? 1'b0 : routes_ready;
    end

    // ==========================================================
    // Serial transmit
    // The line idles high, as a serial line would between frames.
    always_ff @(posedge ref_clk) begin
        data0_in <= sys_rst ? 1'b1 : tx_bit;
    end
endmodule : ckswr_link_model

// ===== tb_ckswr_regs.sv
// Self-checking testbench for the accessory switch and irq register block.
`timescale 1ns/1ps
module tb_ckswr_regs;
    import ckswr_pkg::*;
    logic         ref_clk = 1'b0;
    logic         sys_rst = 1'b1;
    ckswr_bus_t   bus = '0;
    ckswr_sense_t sense_pin = '0;
    logic         sink_en = 1'b0, pullup_en = 1'b0, vend_en = 1'b0, conv_start = 1'b0, code_read = 1'b0;
    logic         dp_in = 1'b0, routes_ready = 1'b0, tx_bit = 1'b1;
    logic [7:0]   rdata;
    logic         mode_sel, data0_in, data1_out, data2_oe, dm_out, dm_oe, id_gnd;
    logic         l_en, r_en, l_pin, r_pin, se_dis, alt_int;
    int           n_mismatch = 0, samples_checked = 0, n_int = 0, n0;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (alt_int === 1'b1) n_int++;

    ckswr_link_model link (.ref_clk(ref_clk), .sys_rst(sys_rst), .routes_ready(routes_ready), .tx_bit(tx_bit),
        .accessory_mode_sel(mode_sel), .data0_in(data0_in));
    ckswr_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .sense_pin(sense_pin),
        .data_sink_current_en(sink_en), .id_pullup_en(pullup_en), .accessory_mode_sel(mode_sel),
        .vendor_res_irq_en(vend_en), .res_convert_start(conv_start), .vendor_code_read(code_read),
        .data0_in(data0_in), .dp_in(dp_in), .data1_out(data1_out), .data2_oe(data2_oe), .dm_out(dm_out),
        .dm_oe(dm_oe), .id_pin_ground_drive(id_gnd), .left_audio_pin_en(l_en), .right_audio_pin_en(r_en),
        .left_audio_pin(l_pin), .right_audio_pin(r_pin), .se_rx_disable(se_dis), .alt_int(alt_int));

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask : bus_wr
    task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1 check(what, exp, rdata);
    endtask : rd_chk
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic pulse_conv(input logic rd_code);
        @(posedge ref_clk);
        if (rd_code) code_read <= 1'b1; else conv_start <= 1'b1;
        @(posedge ref_clk);
        code_read <= 1'b0;
        conv_start <= 1'b0;
    endtask : pulse_conv

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        logic [5:0] amap [9] = '{6'h19, 6'h1A, 6'h1B, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h00, 6'h3F};
        foreach (amap[i]) rd_chk("reset value", amap[i], REG_RESET);
        bus_wr(ADDR_SWITCH_WRITE, 8'hFF);
        for (int i = 0; i < 3; i++) rd_chk("switch", ADDR_SWITCH_WRITE + 6'(i), 8'hFE);
        bus_wr(ADDR_SWITCH_CLEAR, 8'h0D);
        rd_chk("switch clear", ADDR_SWITCH_SET, 8'hF2);
        bus_wr(ADDR_SWITCH_SET, 8'h05);
        rd_chk("switch set", ADDR_SWITCH_CLEAR, 8'hF6);
        bus_wr(ADDR_SWITCH_WRITE, 8'h00);
        bus_wr(ADDR_IRQEN_WRITE, 8'hFF);
        for (int i = 0; i < 3; i++) rd_chk("irq enable", ADDR_IRQEN_WRITE + 6'(i), 8'h27);
        bus_wr(ADDR_IRQEN_CLEAR, 8'h21);
        rd_chk("irq clear", ADDR_IRQEN_WRITE, 8'h06);
        bus_wr(ADDR_IRQEN_SET, 8'h19);
        rd_chk("irq set", ADDR_IRQEN_WRITE, 8'h07);
        bus_wr(ADDR_IRQEN_WRITE, 8'h00);
        bus_wr(ADDR_IRQ_STATUS, 8'hFF);
        rd_chk("status write", ADDR_IRQ_STATUS, 8'h00);
    endtask : t_regs

    task automatic t_routing();
        logic [7:0] sw [6] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40, 8'h60};
        logic [4:0] ex [6] = '{5'h10, 5'h08, 5'h05, 5'h03, 5'h03, 5'h03};
        // audio writes keep route bits clear.
        foreach (sw[i]) begin
            bus_wr(ADDR_SWITCH_WRITE, sw[i]);
            settle();
            check("switch outputs", {3'h0, ex[i]}, {3'h0, id_gnd, dm_oe, l_en, r_en, se_dis});
        end
        bus_wr(ADDR_SWITCH_WRITE, 8'h00);
        dp_in <= 1'b0;
        settle();
        check("data1 idle", 8'h01, {7'h0, data1_out});
        bus_wr(ADDR_SWITCH_WRITE, 8'h0C);
        tx_bit <= 1'b0;
        settle();
        check("rx route", 8'h00, {7'h0, data1_out});
        check("tx route", 8'h01, {6'h0, dm_out, dm_oe});
        dp_in <= 1'b1;
        tx_bit <= 1'b1;
        settle();
        check("rx route high", 8'h01, {7'h0, data1_out});
        check("tx route high", 8'h03, {6'h0, dm_out, dm_oe});
        bus_wr(ADDR_SWITCH_WRITE, 8'h3C);
        settle();
        check("uart on audio", 8'h03, {6'h0, l_pin, r_pin});
        tx_bit <= 1'b0;
        dp_in <= 1'b0;
        settle();
        check("uart on audio low", 8'h00, {6'h0, l_pin, r_pin});
        bus_wr(ADDR_SWITCH_WRITE, 8'h8C);
        routes_ready <= 1'b1;
        settle();
        check("data2 tristate", 8'h00, {7'h0, data2_oe});
        bus_wr(ADDR_SWITCH_WRITE, 8'h0C);
        settle();
        check("data2 driven", 8'h01, {7'h0, data2_oe});
        routes_ready <= 1'b0;
        bus_wr(ADDR_SWITCH_WRITE, 8'h00);
    endtask : t_routing

    task automatic t_events();
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, RES_CODE_FLOAT, RES_CODE_ERROR};
        pullup_en <= 1'b1;
        bus_wr(ADDR_IRQEN_WRITE, 8'h01);
        n0 = n_int;
        sense_pin.id_open <= 1'b1;
        settle();
        check("open rise irq", 8'h01, 8'(n_int - n0));
        rd_chk("status open", ADDR_IRQ_STATUS, 8'h01);
        bus_wr(ADDR_IRQEN_WRITE, 8'h02);
        sense_pin.id_open <= 1'b0;
        settle();
        check("open fall irq", 8'h02, 8'(n_int - n0));
        bus_wr(ADDR_IRQEN_WRITE, 8'h04);
        sense_pin.id_open <= 1'b1;
        sink_en <= 1'b1;
        sense_pin.dp_voltage <= 1'b1;
        settle();
        rd_chk("status detect", ADDR_IRQ_STATUS, 8'h03);
        sense_pin.line_state <= 2'h1;
        settle();
        rd_chk("detect off line", ADDR_IRQ_STATUS, 8'h01);
        sense_pin.dp_voltage <= 1'b0;
        sense_pin.line_state <= LINE_SE0;
        settle();
        check("detect irq", 8'h04, 8'(n_int - n0));
        sense_pin.id_open <= 1'b0;
        foreach (codes[i]) begin
            sense_pin.res_code <= codes[i];
            settle();
            rd_chk("resistor code", ADDR_IRQ_STATUS, {2'h0, codes[i], 3'h0});
        end
        sense_pin.res_code <= 3'h0;
        bus_wr(ADDR_IRQEN_WRITE, 8'h20);
        for (int k = 0; k < 2; k++) begin
            n0 = n_int;
            pulse_conv(1'b0);
            repeat (CONV_CYCLES - 10) @(posedge ref_clk);
            rd_chk("done early", ADDR_IRQ_STATUS, 8'h00);
            repeat (20) @(posedge ref_clk);
            rd_chk("done set", ADDR_IRQ_STATUS, 8'h40);
            rd_chk("done kept", ADDR_IRQ_STATUS, 8'h40);
            check("done irq", 8'h01, 8'(n_int - n0));
            pulse_conv(1'b1);
            rd_chk("done cleared", ADDR_IRQ_STATUS, 8'h00);
            bus_wr(ADDR_IRQEN_WRITE, 8'h00);
            vend_en <= 1'b1;
        end
    endtask : t_events

    // ==========================================================
    // Run control
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_routing();
        t_events();
        tally_and_finish();
    end

    // Two conversions dominate the run, so the limit allows that span plus 5000 cycles.
    initial begin
        repeat (2 * CONV_CYCLES + 5000) @(posedge ref_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_ckswr_regs
